// ===== ecbu_unit.sv
// Event condition break unit: twelve event channels and a software trace channel.
`timescale 1ns/100ps
module ecbu_unit #(
    parameter int CNT_W = ecbu_pkg::ECBU_CNT_W
) (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             rst_i,
    // Processor address, program counter and data bus
    input  wire logic                             cpu_addr_valid_i,
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] cpu_addr_i,
    input  wire logic                             cpu_write_i,
    input  wire logic                             pc_valid_i,
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] pc_i,
    input  wire logic                             cpu_data_valid_i,
    input  wire logic [ecbu_pkg::ECBU_DATA_W-1:0] cpu_data_i,
    input  wire ecbu_pkg::ecbu_size_t             cpu_size_i,
    input  wire logic [ecbu_pkg::ECBU_ADDRESS_SPACE_ID_W-1:0] address_space_id_i,
    // X and Y memory address buses
    input  wire logic                             xbus_valid_i,
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] xbus_addr_i,
    input  wire logic                             ybus_valid_i,
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] ybus_addr_i,
    // System bus
    input  wire logic                             sys_valid_i,
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] sys_addr_i,
    input  wire logic [ecbu_pkg::ECBU_DATA_W-1:0] sys_data_i,
    // Instruction events
    input  wire logic                             tlb_load_instruction_i,
    input  wire logic                             branch_i,
    input  wire logic [ecbu_pkg::ECBU_BRK_W-1:0]  branch_kind_i,
    // Per-channel configuration
    input  wire ecbu_pkg::ecbu_kind_t             ch_kind_i      [ecbu_pkg::ECBU_NUM_CH],
    input  wire ecbu_pkg::ecbu_action_t           ch_action_i    [ecbu_pkg::ECBU_NUM_CH],
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] ch_value_i     [ecbu_pkg::ECBU_NUM_CH],
    input  wire logic [ecbu_pkg::ECBU_ADDR_W-1:0] ch_limit_i     [ecbu_pkg::ECBU_NUM_CH],
    input  wire ecbu_pkg::ecbu_size_t             ch_size_i      [ecbu_pkg::ECBU_NUM_CH],
    input  wire ecbu_pkg::ecbu_sel_t              ch_sel_i       [ecbu_pkg::ECBU_NUM_CH],
    input  wire logic [ecbu_pkg::ECBU_NUM_CH-1:0] ch_rw_en_i,
    input  wire logic [ecbu_pkg::ECBU_NUM_CH-1:0] ch_rw_write_i,
    input  wire logic [ecbu_pkg::ECBU_NUM_CH-1:0] ch_address_space_id_en_i,
    input  wire logic [ecbu_pkg::ECBU_ADDRESS_SPACE_ID_W-1:0] ch_address_space_id_i      [ecbu_pkg::ECBU_NUM_CH],
    input  wire logic [ecbu_pkg::ECBU_NUM_CH-1:0] ch_count_en_i,
    input  wire logic [CNT_W-1:0]                 ch_count_i     [ecbu_pkg::ECBU_NUM_CH],
    // Branch trace enable control
    input  wire logic                             branch_trace_we_i,
    input  wire logic                             branch_trace_en_i,
    output logic                                  branch_trace_en_o,
    // Software trace channel
    input  wire logic                             sw_trace_en_i,
    input  wire logic                             sw_trace_valid_i,
    input  wire logic [ecbu_pkg::ECBU_DATA_W-1:0] sw_trace_data_i,
    output logic                                  sw_trace_valid_o,
    output logic [ecbu_pkg::ECBU_DATA_W-1:0]      sw_trace_data_o,
    // Event outputs toward the processor and debug host
    output logic                                  break_req_o,
    output logic [ecbu_pkg::ECBU_NUM_CH-1:0]      match_o,
    output logic [ecbu_pkg::ECBU_NUM_CH-1:0]      trace_capture_o,
    output logic                                  perf_start_o,
    output logic                                  perf_stop_o
);
    import ecbu_pkg::*;

    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
        $error("ecbu_unit: CNT_W must lie between 1 and 32");
    end

    // Compares two words only over the lanes that the access size covers.
    function automatic logic size_equal(input logic [ECBU_DATA_W-1:0] a,
                                        input logic [ECBU_DATA_W-1:0] b,
                                        input ecbu_size_t             sz);
        case (sz)
            ECBU_SIZE_BYTE: size_equal = (a[7:0] == b[7:0]);
            ECBU_SIZE_WORD: size_equal = (a[15:0] == b[15:0]);
            default:        size_equal = (a == b);
        endcase
    endfunction : size_equal

    logic [ECBU_NUM_CH-1:0] raw_hit;
    logic [ECBU_NUM_CH-1:0] qual_hit;
    logic [ECBU_NUM_CH-1:0] fire;

    // ==========================================================================
    // Raw match per channel
    // ==========================================================================
    // Channels that cannot serve a configured kind never match, so software
    // cannot widen a channel beyond what its comparators are built for.
    always_comb begin
        for (int c = 0; c < ECBU_NUM_CH; c++) begin
            raw_hit[c]  = 1'b0;
            qual_hit[c] = 1'b0;
            case (ch_kind_i[c])
                ECBU_KIND_ADDR: begin
                    raw_hit[c] = ECBU_CAP_ADDR[c]
                        && ((cpu_addr_valid_i && cpu_addr_i == ch_value_i[c])
                        ||  (pc_valid_i && pc_i == ch_value_i[c]));
                end
                ECBU_KIND_DATA: begin
                    raw_hit[c] = ECBU_CAP_DATA[c] && cpu_data_valid_i
                        && cpu_size_i == ch_size_i[c]
                        && size_equal(cpu_data_i, ch_value_i[c], ch_size_i[c]);
                end
                ECBU_KIND_BUS: begin
                    case (ch_sel_i[c])
                        ECBU_SEL_XADDR: raw_hit[c] = xbus_valid_i
                            && xbus_addr_i == ch_value_i[c];
                        ECBU_SEL_YADDR: raw_hit[c] = ybus_valid_i
                            && ybus_addr_i == ch_value_i[c];
                        default:        raw_hit[c] = cpu_data_valid_i
                            && cpu_data_i == ch_value_i[c];
                    endcase
                    raw_hit[c] = raw_hit[c] && ECBU_CAP_BUS[c]
                        && (!ch_rw_en_i[c] || cpu_write_i == ch_rw_write_i[c]);
                end
                ECBU_KIND_WINDOW: begin
                    raw_hit[c] = ECBU_CAP_WINDOW[c] && cpu_addr_valid_i
                        && cpu_addr_i >= ch_value_i[c] && cpu_addr_i <= ch_limit_i[c];
                end
                ECBU_KIND_SYS: begin
                    raw_hit[c] = ECBU_CAP_SYS[c] && sys_valid_i
                        && ((ch_sel_i[c] == ECBU_SEL_DATA) ? (sys_addr_i == ch_value_i[c])
                                                           : (sys_data_i == ch_value_i[c]));
                end
                ECBU_KIND_TLB: begin
                    raw_hit[c] = ECBU_CAP_TLB[c] && tlb_load_instruction_i;
                end
                ECBU_KIND_BRANCH: begin
                    raw_hit[c] = ECBU_CAP_BRANCH[c] && branch_i
                        && (ch_value_i[c][ECBU_BRK_W-1:0] == '0
                        ||  (branch_kind_i & ch_value_i[c][ECBU_BRK_W-1:0]) != '0);
                end
                default: begin
                    raw_hit[c] = 1'b0;
                end
            endcase
            qual_hit[c] = raw_hit[c] && (!(ch_address_space_id_en_i[c] && ECBU_CAP_ADDRESS_SPACE_ID[c])
                || address_space_id_i == ch_address_space_id_i[c]);
        end
    end

    // ==========================================================================
    // Count qualifiers
    // ==========================================================================
    // twelve channels
    for (genvar g = 0; g < ECBU_NUM_CH; g++) begin : g_count
        ecbu_counter #(
            .CNT_W    (CNT_W)
        ) u_count (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .enable_i (ch_count_en_i[g] && ECBU_CAP_COUNT[g]),
            .target_i (ch_count_i[g]),
            .hit_i    (qual_hit[g]),
            .fire_o   (fire[g])
        );
    end

    // ==========================================================================
    // Actions
    // ==========================================================================
    logic                   branch_trace_en;
    logic                   next_branch_trace_en;
    logic                   next_break;
    logic                   next_perf_start;
    logic                   next_perf_stop;
    logic [ECBU_NUM_CH-1:0] next_trace;
    logic                   next_sw_valid;
    logic [ECBU_DATA_W-1:0] next_sw_data;

    always_comb begin
        next_branch_trace_en = branch_trace_we_i ? branch_trace_en_i : branch_trace_en;
        next_break           = 1'b0;
        next_perf_start      = 1'b0;
        next_perf_stop       = 1'b0;
        next_trace           = '0;
        for (int c = 0; c < ECBU_NUM_CH; c++) begin
            case (ch_action_i[c])
                ECBU_ACT_TRACE: begin
                    next_trace[c] = fire[c] && ECBU_ACT_TRC[c]
                        && (!ECBU_CAP_BRANCH[c] || branch_trace_en);
                end
                ECBU_ACT_PERF_START: begin
                    next_perf_start = next_perf_start || (fire[c] && ECBU_ACT_PERF[c]);
                end
                ECBU_ACT_PERF_STOP: begin
                    next_perf_stop = next_perf_stop || (fire[c] && ECBU_ACT_PERF[c]);
                end
                default: begin
                    next_break = next_break || (fire[c] && ECBU_ACT_BRK[c]);
                end
            endcase
        end
        next_break = next_break || fire[ECBU_TLB_CH];
        next_sw_valid = sw_trace_en_i && sw_trace_valid_i;
        next_sw_data  = next_sw_valid ? sw_trace_data_i : sw_trace_data_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            branch_trace_en  <= ECBU_BRANCH_TRACE_RST;
            break_req_o      <= 1'b0;
            match_o          <= '0;
            trace_capture_o  <= '0;
            perf_start_o     <= 1'b0;
            perf_stop_o      <= 1'b0;
            sw_trace_valid_o <= 1'b0;
            sw_trace_data_o  <= '0;
        end else begin
            branch_trace_en  <= next_branch_trace_en;
            break_req_o      <= next_break;
            match_o          <= fire;
            trace_capture_o  <= next_trace;
            perf_start_o     <= next_perf_start;
            perf_stop_o      <= next_perf_stop;
            sw_trace_valid_o <= next_sw_valid;
            sw_trace_data_o  <= next_sw_data;
        end
    end

    assign branch_trace_en_o = branch_trace_en;

endmodule : ecbu_unit

// ===== ecbu_pkg.sv
// Package of shared constants and types for the event condition break unit.
package ecbu_pkg;

    // ==========================================================================
    // Channel structure
    // ==========================================================================
    localparam int ECBU_NUM_CH  = 12;
    localparam int ECBU_ADDR_W  = 32;
    localparam int ECBU_DATA_W  = 32;
    localparam int ECBU_ADDRESS_SPACE_ID_W  = 8;
    localparam int ECBU_BRK_W   = 4;
    localparam int ECBU_CNT_W   = 16;
    // Zero-based index of channel seven, the instruction-only channel.
    localparam int ECBU_TLB_CH  = 6;

    // ==========================================================================
    // Per-channel capability masks, bit 0 is channel one
    // ==========================================================================
    localparam logic [11:0] ECBU_CAP_ADDR   = 12'h78f;
    localparam logic [11:0] ECBU_CAP_DATA   = 12'h402;
    localparam logic [11:0] ECBU_CAP_ADDRESS_SPACE_ID   = 12'h63f;
    localparam logic [11:0] ECBU_CAP_BUS    = 12'h633;
    localparam logic [11:0] ECBU_CAP_WINDOW = 12'h030;
    localparam logic [11:0] ECBU_CAP_SYS    = 12'h180;
    localparam logic [11:0] ECBU_CAP_TLB    = 12'h040;
    localparam logic [11:0] ECBU_CAP_COUNT  = 12'h402;
    localparam logic [11:0] ECBU_CAP_BRANCH = 12'h800;
    localparam logic [11:0] ECBU_ACT_BRK    = 12'hfff;
    localparam logic [11:0] ECBU_ACT_TRC    = 12'h9b0;
    localparam logic [11:0] ECBU_ACT_PERF   = 12'hfbf;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic ECBU_BRANCH_TRACE_RST = 1'b1;

    // ==========================================================================
    // Enumerations
    // ==========================================================================
    typedef enum logic [2:0] {
        ECBU_KIND_OFF,
        ECBU_KIND_ADDR,
        ECBU_KIND_DATA,
        ECBU_KIND_BUS,
        ECBU_KIND_WINDOW,
        ECBU_KIND_SYS,
        ECBU_KIND_TLB,
        ECBU_KIND_BRANCH
    } ecbu_kind_t;

    typedef enum logic [1:0] {
        ECBU_ACT_BREAK,
        ECBU_ACT_TRACE,
        ECBU_ACT_PERF_START,
        ECBU_ACT_PERF_STOP
    } ecbu_action_t;

    typedef enum logic [1:0] {
        ECBU_SIZE_BYTE,
        ECBU_SIZE_WORD,
        ECBU_SIZE_LONG
    } ecbu_size_t;

    // Bus selection for bus-state events; for system-bus events, 0 = address, 1 = data.
    typedef enum logic [1:0] {
        ECBU_SEL_DATA,
        ECBU_SEL_XADDR,
        ECBU_SEL_YADDR
    } ecbu_sel_t;

endpackage : ecbu_pkg

// ===== ecbu_counter.sv
// Occurrence counter that qualifies one channel's match.
`timescale 1ns/100ps
module ecbu_counter #(
    parameter int CNT_W = ecbu_pkg::ECBU_CNT_W
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Qualifier control
    input  wire logic             enable_i,
    input  wire logic [CNT_W-1:0] target_i,
    // Match in and qualified match out
    input  wire logic             hit_i,
    output logic                  fire_o
);
    import ecbu_pkg::*;

    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
        $error("ecbu_counter: CNT_W must lie between 1 and 32");
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W:0]   seen;

    // ==========================================================================
    // Counting
    // ==========================================================================
    // count to target
    always_comb begin
        seen       = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};
        next_count = count;
        fire_o     = hit_i;
        if (!enable_i) begin
            next_count = '0;
        end else if (hit_i) begin
            // A target of zero or one fires on every occurrence.
            if (seen >= {1'b0, target_i}) begin
                fire_o     = 1'b1;
                next_count = '0;
            end else begin
                fire_o     = 1'b0;
                next_count = seen[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : ecbu_counter

// ===== ecbu_monitor.sv
// Port-level assertions for the event condition break unit.
`timescale 1ns/100ps
module ecbu_monitor #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic                             clk_i,
    input wire logic                             rst_i,
    // Observed inputs
    input wire logic                             tlb_load_instruction_i,
    input wire ecbu_pkg::ecbu_kind_t             ch_kind_i [ecbu_pkg::ECBU_NUM_CH],
    input wire logic                             branch_trace_we_i,
    input wire logic                             branch_trace_en_i,
    input wire logic                             sw_trace_en_i,
    input wire logic                             sw_trace_valid_i,
    input wire logic [ecbu_pkg::ECBU_DATA_W-1:0] sw_trace_data_i,
    // Observed outputs
    input wire logic                             branch_trace_en_o,
    input wire logic                             sw_trace_valid_o,
    input wire logic [ecbu_pkg::ECBU_DATA_W-1:0] sw_trace_data_o,
    input wire logic                             break_req_o,
    input wire logic [ecbu_pkg::ECBU_NUM_CH-1:0] match_o,
    input wire logic [ecbu_pkg::ECBU_NUM_CH-1:0] trace_capture_o,
    input wire logic                             perf_start_o,
    input wire logic                             perf_stop_o
);
    import ecbu_pkg::*;
    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_SWT_TAKE: assert property (sw_trace_en_i && sw_trace_valid_i |=>
        sw_trace_valid_o && sw_trace_data_o == $past(sw_trace_data_i))
        else $error("Software trace record not captured.");
    AST_SWT_GATE: assert property (!(sw_trace_en_i && sw_trace_valid_i) |=>
        !sw_trace_valid_o && $stable(sw_trace_data_o))
        else $error("Software trace output moved without a record.");
    AST_BRK_MERGE: assert property (break_req_o |-> match_o != 12'h000)
        else $error("Break request without a channel match.");
    AST_TRC_SUB: assert property (
        (trace_capture_o & ~(match_o & ECBU_ACT_TRC)) == 12'h000)
        else $error("Trace capture on a channel that did not match or cannot trace.");
    AST_PERF_SRC: assert property ((perf_start_o || perf_stop_o) |->
        (match_o & ECBU_ACT_PERF) != 12'h000)
        else $error("Performance event without a capable matching channel.");
    AST_CH4_KIND: assert property (ch_kind_i[3] != ECBU_KIND_ADDR |=> !match_o[3])
        else $error("Channel four matched on a kind it does not support.");
    AST_TLB_BRK: assert property (tlb_load_instruction_i &&
        ch_kind_i[ECBU_TLB_CH] == ECBU_KIND_TLB |=> match_o[ECBU_TLB_CH] && break_req_o)
        else $error("TLB load instruction did not break.");
    AST_BTE_RST: assert property ($fell(rst_i) |-> branch_trace_en_o)
        else $error("Branch trace enable not set after reset.");
    AST_BTE_LOAD: assert property (branch_trace_we_i |=>
        branch_trace_en_o == $past(branch_trace_en_i))
        else $error("Branch trace enable not loaded.");
    AST_BTE_KEEP: assert property (!branch_trace_we_i |=> $stable(branch_trace_en_o))
        else $error("Branch trace enable changed without a write.");
    COV_MULTI: cover property (break_req_o && $countones(match_o) > 1);
    COV_SWT: cover property (sw_trace_valid_o);
    COV_TLB: cover property (match_o[ECBU_TLB_CH] && break_req_o);
endmodule : ecbu_monitor

bind ecbu_unit ecbu_monitor #(.CNT_W(CNT_W)) i_ecbu_monitor (
    .clk_i, .rst_i, .tlb_load_instruction_i, .ch_kind_i, .branch_trace_we_i,
    .branch_trace_en_i, .sw_trace_en_i, .sw_trace_valid_i, .sw_trace_data_i,
    .branch_trace_en_o, .sw_trace_valid_o, .sw_trace_data_o, .break_req_o, .match_o,
    .trace_capture_o, .perf_start_o, .perf_stop_o
);

// ===== ecbu_core_model.sv
// Processor-side bus model that presents one access per request.
`timescale 1ns/100ps
module ecbu_core_model (
    // Request
    input  wire logic        go_i,
    input  wire logic [31:0] val_i,
    input  wire logic        write_i,
    input  wire ecbu_pkg::ecbu_size_t size_i,
    // Monitored buses
    output logic             addr_valid_o,
    output logic [31:0]      bus_o,
    output logic             write_o,
    output ecbu_pkg::ecbu_size_t size_o,
    output logic             tlb_o,
    output logic             branch_o,
    output logic [3:0]       branch_kind_o
);
    import ecbu_pkg::*;
    // Idle buses show the inverse value so a stale match cannot linger.
    assign bus_o         = go_i ? val_i : ~val_i;
    assign addr_valid_o  = go_i;
    assign write_o       = go_i ? write_i : ~write_i;
    assign size_o        = size_i;
    assign tlb_o         = go_i;
    assign branch_o      = go_i;
    assign branch_kind_o = bus_o[3:0];
endmodule : ecbu_core_model

// ===== testbench.sv
// Self-checking bench for the event condition break unit.
`timescale 1ns/100ps
module testbench;
    import ecbu_pkg::*;
    // ==========================================================================
    // Signals
    // ==========================================================================
    logic clk_i, rst_i, go, wr, av, cpu_write_i, tlb_load_instruction_i, branch_i;
    logic [31:0] val, bus, r, v;
    ecbu_size_t cpu_size_i, sz = ECBU_SIZE_LONG;
    logic [7:0] address_space_id_i;
    logic [3:0] branch_kind_i;
    ecbu_kind_t ch_kind_i [12];
    ecbu_action_t ch_action_i [12];
    logic [31:0] ch_value_i [12], ch_limit_i [12];
    ecbu_size_t ch_size_i [12];
    ecbu_sel_t ch_sel_i [12];
    logic [11:0] ch_rw_en_i, ch_rw_write_i, ch_address_space_id_en_i, ch_count_en_i, mk;
    logic [7:0] ch_address_space_id_i [12];
    logic [15:0] ch_count_i [12];
    logic branch_trace_we_i, branch_trace_en_i, branch_trace_en_o, m;
    logic sw_trace_en_i, sw_trace_valid_i, sw_trace_valid_o, break_req_o, perf_start_o, perf_stop_o;
    logic [31:0] sw_trace_data_i, sw_trace_data_o;
    logic [11:0] match_o, trace_capture_o;
    int errors, check_count;
    integer seed = 32'h7258;

    ecbu_core_model i_ecbu_core_model (.go_i(go), .val_i(val), .write_i(wr), .addr_valid_o(av),
        .bus_o(bus), .write_o(cpu_write_i), .size_o(cpu_size_i), .tlb_o(tlb_load_instruction_i),
        .branch_o(branch_i), .branch_kind_o(branch_kind_i), .size_i(sz));
    ecbu_unit #(.CNT_W(16)) i_ecbu_unit (.clk_i, .rst_i, .cpu_addr_valid_i(av),
        .cpu_addr_i(bus), .cpu_write_i, .pc_valid_i(av), .pc_i(bus), .cpu_data_valid_i(av),
        .cpu_data_i(bus), .cpu_size_i, .address_space_id_i, .xbus_valid_i(av), .xbus_addr_i(bus),
        .ybus_valid_i(av), .ybus_addr_i(bus), .sys_valid_i(av), .sys_addr_i(bus),
        .sys_data_i(bus), .tlb_load_instruction_i, .branch_i, .branch_kind_i, .ch_kind_i,
        .ch_action_i, .ch_value_i, .ch_limit_i, .ch_size_i, .ch_sel_i, .ch_rw_en_i,
        .ch_rw_write_i, .ch_address_space_id_en_i, .ch_address_space_id_i, .ch_count_en_i, .ch_count_i,
        .branch_trace_we_i, .branch_trace_en_i, .branch_trace_en_o, .sw_trace_en_i,
        .sw_trace_valid_i, .sw_trace_data_i, .sw_trace_valid_o, .sw_trace_data_o, .break_req_o,
        .match_o, .trace_capture_o, .perf_start_o, .perf_stop_o);

    // ==========================================================================
    // Tasks and expectations
    // ==========================================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick

    // One access is presented for one cycle; outputs are read after the next edge.
    task automatic strike(input logic [31:0] a);
        tick();
        val = a;
        go = 1'b1;
        tick();
        go = 1'b0;
    endtask : strike

    task automatic idle();
        for (int i = 0; i < 12; i++) begin
            ch_kind_i[i] = ECBU_KIND_OFF;
            ch_action_i[i] = ECBU_ACT_BREAK;
            {ch_value_i[i], ch_limit_i[i], ch_address_space_id_i[i], ch_count_i[i]} = 88'h0;
            ch_size_i[i] = ECBU_SIZE_LONG;
            ch_sel_i[i] = ECBU_SEL_DATA;
        end
        {ch_rw_en_i, ch_rw_write_i, ch_address_space_id_en_i, ch_count_en_i} = 48'h0;
    endtask : idle

    function automatic logic [11:0] cap(input ecbu_kind_t k);
        case (k)
            ECBU_KIND_ADDR:   return ECBU_CAP_ADDR;
            ECBU_KIND_DATA:   return ECBU_CAP_DATA;
            ECBU_KIND_BUS:    return ECBU_CAP_BUS;
            ECBU_KIND_WINDOW: return ECBU_CAP_WINDOW;
            ECBU_KIND_SYS:    return ECBU_CAP_SYS;
            ECBU_KIND_TLB:    return ECBU_CAP_TLB;
            ECBU_KIND_BRANCH: return ECBU_CAP_BRANCH;
            default:          return 12'h000;
        endcase
    endfunction : cap

    // ==========================================================================
    // Clock, watchdog and sequence
    // ==========================================================================
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Whole sequence needs about 230 cycles; a hang is cut well beyond that.
    initial begin
        #20000;
        errors++;
        close_out();
    end

    initial begin
        {rst_i, go, wr, val, address_space_id_i, branch_trace_we_i} = {2'b10, 42'h0};
        {branch_trace_en_i, sw_trace_en_i, sw_trace_valid_i, sw_trace_data_i} = 35'h0;
        idle();
        repeat (10) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        check({match_o, break_req_o, trace_capture_o, branch_trace_en_o}, 26'h1);
        for (int c = 0; c < 12; c++) begin
            for (int k = 1; k < 8; k++) begin
                r = $random(seed);
                v = $random(seed);
                idle();
                ch_kind_i[c] = ecbu_kind_t'(k);
                ch_action_i[c] = ecbu_action_t'(r[1:0]);
                ch_value_i[c] = (k == 7) ? 32'h0 : v;
                ch_limit_i[c] = v;
                mk = cap(ecbu_kind_t'(k));
                m = mk[c];
                strike(v);
                check(match_o, {11'h0, m} << c);
                check(break_req_o, m & ((r[1:0] == 2'h0 & ECBU_ACT_BRK[c]) | k == 6));
                check(trace_capture_o, {11'h0, m & r[1:0] == 2'h1 & ECBU_ACT_TRC[c]} << c);
                check({perf_stop_o, perf_start_o}, {m & r[1:0] == 2'h3 & ECBU_ACT_PERF[c],
                    m & r[1:0] == 2'h2 & ECBU_ACT_PERF[c]});
            end
        end
        for (int c = 1; c < 11; c += 9) begin
            idle();
            ch_kind_i[c] = ECBU_KIND_ADDR;
            ch_value_i[c] = 32'h0000_1234;
            ch_count_en_i[c] = 1'b1;
            ch_count_i[c] = 16'h0003;
            for (int n = 1; n < 7; n++) begin
                strike(32'h0000_1234);
                check(match_o[c], n % 3 == 0);
            end
        end
        idle();
        for (int i = 0; i < 12; i++) begin
            ch_kind_i[i] = ECBU_KIND_ADDR;
            ch_value_i[i] = 32'h0000_0040;
        end
        strike(32'h0000_0040);
        check(match_o, ECBU_CAP_ADDR);
        check(break_req_o, 1'b1);
        idle();
        {ch_kind_i[0], ch_kind_i[3]} = {ECBU_KIND_BUS, ECBU_KIND_ADDR};
        {ch_value_i[0], ch_value_i[3], ch_address_space_id_i[3]} = {64'h99_0000_0099, 8'h5a};
        {ch_rw_en_i[0], ch_rw_write_i[0], ch_address_space_id_en_i[3]} = 3'b111;
        for (int n = 0; n < 2; n++) begin
            wr = n[0];
            address_space_id_i = n[0] ? 8'h5a : 8'h5b;
            strike(32'h0000_0099);
            check(match_o[0], n[0]);
            check(match_o[3], n[0]);
        end
        idle();
        ch_kind_i[4] = ECBU_KIND_WINDOW;
        {ch_value_i[4], ch_limit_i[4]} = {32'h0000_2000, 32'h0000_2004};
        for (int n = 0; n < 7; n++) begin
            strike(32'h0000_1fff + n);
            check(match_o[4], n > 0 && n < 6);
        end
        // branch trace disabled blocks channel twelve trace only
        branch_trace_we_i = 1'b1;
        tick();
        branch_trace_we_i = 1'b0;
        check(branch_trace_en_o, 1'b0);
        idle();
        ch_kind_i[11] = ECBU_KIND_BRANCH;
        ch_action_i[11] = ECBU_ACT_TRACE;
        strike(32'h0000_0000);
        check({match_o[11], trace_capture_o[11]}, 2'b10);
        // byte compare ignores the upper lanes
        idle();
        ch_kind_i[1] = ECBU_KIND_DATA;
        ch_size_i[1] = ECBU_SIZE_BYTE;
        ch_value_i[1] = 32'h0000_00a5;
        sz = ECBU_SIZE_BYTE;
        strike(32'h1234_56a5);
        check(match_o[1], 1'b1);
        // software trace gated by its enable
        {sw_trace_en_i, sw_trace_valid_i, sw_trace_data_i} = {2'b11, 32'hcafe_0123};
        tick();
        check({sw_trace_valid_o, sw_trace_data_o}, {1'b1, 32'hcafe_0123});
        {sw_trace_en_i, sw_trace_valid_i, sw_trace_data_i} = {2'b01, 32'h0bad_0bad};
        tick();
        sw_trace_valid_i = 1'b0;
        check({sw_trace_valid_o, sw_trace_data_o}, {1'b0, 32'hcafe_0123});
        close_out();
    end
endmodule : testbench
